//--- core/gev_cfg.svh
// Register offsets, field positions, reset values and rule summary of the GPIO event block.
// What this block does
// RL1 - Unmasked qualifying edge on an IO sets its interrupt-source flag.
// RL2 - Writing one to an interrupt-source flag clears it and the event flag.
// RL3 - Interrupt output returns high once all source flags are clear.
// RL4 - Selected edge sets the event-status flag regardless of the mask.
// RL5 - Writing one to an event flag clears it and the source flag.
// RL6 - Changing an IO's edge sensitivity clears its pending flags.
// RL7 - Source field picks off, external pin, or internal 1MHz oscillator.
// RL8 - Pin direction bit makes the shared oscillator pin input or output.
// RL9 - Output field drives low, high, or oscillator divided by 2^(n-1).
// RL10 - Mask bit zero lets events interrupt; one blocks them.
// RL11 - Two-bit sense code: none, rising, falling, or both edges.
// RL12 - Interrupt output stays low while any source flag is set.
`ifndef GEV_CFG_SVH
`define GEV_CFG_SVH
`define GEV_OFS_MASK     8'h09
`define GEV_OFS_SENSE    8'h0A
`define GEV_OFS_SRC      8'h0B
`define GEV_OFS_EVT      8'h0C
`define GEV_OFS_CLK      8'h0D
`define GEV_RST_MASK     4'hF
`define GEV_RST_SENSE    8'h00
`define GEV_RST_CLK      8'h00
`define GEV_CLK_SRC_HI   6
`define GEV_CLK_SRC_LO   5
`define GEV_CLK_DIR_BIT  4
`define GEV_CLK_DIV_HI   3
`define GEV_CLK_DIV_LO   0
`define GEV_INT_OSC_HZ   1000000
`define GEV_CORE_HZ      100000000
`define GEV_INT_OSC_DIV  (`GEV_CORE_HZ / `GEV_INT_OSC_HZ / 2)
`endif

//--- core/gev_pkg.sv
// Types shared by the GPIO event block.
package gev_pkg;
  typedef enum logic [1:0] {
    GEV_SRC_OFF,
    GEV_SRC_EXT,
    GEV_SRC_INT,
    GEV_SRC_RSV
  } gev_src_t;
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gev_req_t;
endpackage

//--- core/gev_top.sv
// GPIO event flags, interrupt output and oscillator pin control.
`timescale 1ns/1ps
`default_nettype none
`include "gev_cfg.svh"
module gev_top
  import gev_pkg::*;
(
  // Clock and reset.
  input  wire logic       CORE_CLK_I,
  input  wire logic       SYS_RST_I,
  // Register port, core clock domain.
  input  wire gev_req_t   REQ_I,
  output var  logic [7:0] RDATA_O,
  // IO lines from pins.
  input  wire logic [3:0] IO_I,
  // Interrupt, open drain, active low.
  output var  logic       INTERRUPT_OUT_N_O,
  output var  logic       INTERRUPT_OUT_N_OE_O,
  // Shared oscillator pin.
  input  wire logic       SHARED_OSC_PIN_I,
  output var  logic       SHARED_OSC_PIN_O,
  output var  logic       SHARED_OSC_PIN_OE_O
);
  //--------------------------------------------------------------------
  // Input synchronisers
  //--------------------------------------------------------------------
  logic [3:0] io_s1_r, io_s2_r, io_d_r;
  logic       osc_s1_r, osc_s2_r;
  always_ff @(posedge CORE_CLK_I) begin
    io_s1_r  <= IO_I;
    io_s2_r  <= io_s1_r;
    io_d_r   <= io_s2_r;
    osc_s1_r <= SHARED_OSC_PIN_I;
    osc_s2_r <= osc_s1_r;
  end

  //--------------------------------------------------------------------
  // Edge detection and flags
  //--------------------------------------------------------------------
  function automatic logic edge_hit(input logic [1:0] s, input logic now, input logic old);
    // 01 rising, 10 falling, 11 both, 00 none.
    edge_hit = (s[0] && now && !old) || (s[1] && !now && old);
  endfunction

  logic [3:0] mask_r, mask_nxt, src_r, src_nxt, evt_r, evt_nxt;
  logic [7:0] sense_r, sense_nxt, clk_r, clk_nxt;
  logic [3:0] hit, clr, sense_chg;
  logic       wr_sense;

  always_comb begin
    wr_sense  = REQ_I.wr && REQ_I.addr == `GEV_OFS_SENSE;
    mask_nxt  = mask_r;
    sense_nxt = sense_r;
    clk_nxt   = clk_r;
    clr       = 4'h0;
    sense_chg = 4'h0;
    if (REQ_I.wr) begin
      case (REQ_I.addr)
        `GEV_OFS_MASK:  mask_nxt  = REQ_I.wdata[3:0];
        `GEV_OFS_SENSE: sense_nxt = REQ_I.wdata;
        `GEV_OFS_CLK:   clk_nxt   = {1'b0, REQ_I.wdata[6:0]};
        // RL2 source W1C clears both; upper bits 7:4 ignored.
        `GEV_OFS_SRC:   clr       = REQ_I.wdata[3:0];
        // RL5 event W1C clears both.
        `GEV_OFS_EVT:   clr       = REQ_I.wdata[3:0];
        default:        clr       = 4'h0;
      endcase
    end
    for (int i = 0; i < 4; i++) begin
      // RL11 per-IO sense decode.
      hit[i] = edge_hit(sense_r[2*i+:2], io_s2_r[i], io_d_r[i]);
      // RL6 sense change clears flags.
      sense_chg[i] = wr_sense && (REQ_I.wdata[2*i+:2] != sense_r[2*i+:2]);
    end
    // RL4 events set regardless of mask; set wins over clear.
    evt_nxt = (evt_r & ~(clr | sense_chg)) | hit;
    // RL1 RL10 unmasked events set source flags.
    src_nxt = (src_r & ~(clr | sense_chg)) | (hit & ~mask_r);
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      mask_r  <= `GEV_RST_MASK;
      sense_r <= `GEV_RST_SENSE;
      clk_r   <= `GEV_RST_CLK;
      src_r   <= 4'h0;
      evt_r   <= 4'h0;
    end else begin
      mask_r  <= mask_nxt;
      sense_r <= sense_nxt;
      clk_r   <= clk_nxt;
      src_r   <= src_nxt;
      evt_r   <= evt_nxt;
    end
  end

  //--------------------------------------------------------------------
  // Read data and interrupt
  //--------------------------------------------------------------------
  logic [7:0] rdata_nxt;
  logic       int_n_nxt;
  always_comb begin
    case (REQ_I.addr)
      `GEV_OFS_MASK:  rdata_nxt = {4'h0, mask_r};
      `GEV_OFS_SENSE: rdata_nxt = sense_r;
      `GEV_OFS_SRC:   rdata_nxt = {4'h0, src_r};
      `GEV_OFS_EVT:   rdata_nxt = {4'h0, evt_r};
      `GEV_OFS_CLK:   rdata_nxt = clk_r;
      default:        rdata_nxt = 8'h00;
    endcase
    // RL3 RL12 low while any source set.
    int_n_nxt = ~|src_r;
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      RDATA_O              <= 8'h00;
      INTERRUPT_OUT_N_O    <= 1'b0;
      INTERRUPT_OUT_N_OE_O <= 1'b0;
    end else begin
      RDATA_O              <= rdata_nxt;
      INTERRUPT_OUT_N_O    <= 1'b0;
      INTERRUPT_OUT_N_OE_O <= ~int_n_nxt;
    end
  end

  //--------------------------------------------------------------------
  // Oscillator source and output divider
  //--------------------------------------------------------------------
  gev_src_t    src_sel;
  logic [15:0] ocnt_r, ocnt_nxt;
  logic        iosc_r, iosc_nxt, osc_frequency, osc_frequency_prev_r, osc_frequency_rise;
  logic [14:0] div_r, div_nxt;
  logic [3:0]  dsel;
  logic        pin_nxt, oe_nxt;
  always_comb begin
    src_sel = gev_src_t'(clk_r[`GEV_CLK_SRC_HI:`GEV_CLK_SRC_LO]);
    dsel    = clk_r[`GEV_CLK_DIV_HI:`GEV_CLK_DIV_LO];
    ocnt_nxt = ocnt_r + 16'h0001;
    iosc_nxt = iosc_r;
    if (ocnt_r == 16'(`GEV_INT_OSC_DIV - 1)) begin
      ocnt_nxt = 16'h0000;
      iosc_nxt = ~iosc_r;
    end
    // RL7 source select; off and reserved give no clock.
    // A pin driven as output cannot also carry the external clock.
    case (src_sel)
      GEV_SRC_EXT: osc_frequency = osc_s2_r & ~clk_r[`GEV_CLK_DIR_BIT];
      GEV_SRC_INT: osc_frequency = iosc_r;
      default:     osc_frequency = 1'b0;
    endcase
    osc_frequency_rise = osc_frequency && !osc_frequency_prev_r;
    div_nxt = osc_frequency_rise ? div_r + 15'h0001 : div_r;
    // RL9 fixed levels or divide by 2^(n-1).
    case (dsel)
      4'h0:    pin_nxt = 1'b0;
      4'hF:    pin_nxt = 1'b1;
      4'h1:    pin_nxt = osc_frequency;
      default: pin_nxt = div_r[dsel - 4'h2];
    endcase
    // RL8 direction bit drives the pin enable.
    oe_nxt = clk_r[`GEV_CLK_DIR_BIT];
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      ocnt_r              <= 16'h0000;
      iosc_r              <= 1'b0;
      osc_frequency_prev_r         <= 1'b0;
      div_r               <= 15'h0000;
      SHARED_OSC_PIN_O    <= 1'b0;
      SHARED_OSC_PIN_OE_O <= 1'b0;
    end else begin
      ocnt_r              <= ocnt_nxt;
      iosc_r              <= iosc_nxt;
      osc_frequency_prev_r         <= osc_frequency;
      div_r               <= div_nxt;
      SHARED_OSC_PIN_O    <= pin_nxt;
      SHARED_OSC_PIN_OE_O <= oe_nxt;
    end
  end

  //--------------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SYS_RST_I);

  sequence s_any_src;
    |src_r;
  endsequence
  property p_int_low;
    s_any_src |=> INTERRUPT_OUT_N_OE_O;
  endproperty
  a_int_low: assert property (p_int_low) else $error("Interrupt not driven low."); // RL12
  property p_int_rel;
    (src_r == 4'h0) |=> !INTERRUPT_OUT_N_OE_O;
  endproperty
  a_int_rel: assert property (p_int_rel) else $error("Interrupt not released."); // RL3
  property p_mask_src;
    (hit[0] && !mask_r[0]) |=> src_r[0];
  endproperty
  a_mask_src: assert property (p_mask_src) else $error("Source flag not set."); // RL1
  property p_masked;
    (mask_r[1] && !src_r[1]) |=> !src_r[1];
  endproperty
  a_masked: assert property (p_masked) else $error("Masked line raised source."); // RL10
  property p_evt_set;
    hit[1] |=> evt_r[1];
  endproperty
  a_evt_set: assert property (p_evt_set) else $error("Event flag not set."); // RL4
  property p_w1c_src;
    (REQ_I.wr && REQ_I.addr == `GEV_OFS_SRC && REQ_I.wdata[0] && !hit[0])
      |=> !src_r[0] && !evt_r[0];
  endproperty
  a_w1c_src: assert property (p_w1c_src) else $error("Source clear failed."); // RL2
  property p_w1c_evt;
    (REQ_I.wr && REQ_I.addr == `GEV_OFS_EVT && REQ_I.wdata[0] && !hit[0])
      |=> !evt_r[0] && !src_r[0];
  endproperty
  a_w1c_evt: assert property (p_w1c_evt) else $error("Event clear failed."); // RL5
  property p_sense_clr;
    (sense_chg[0] && !hit[0]) |=> !evt_r[0] && !src_r[0];
  endproperty
  a_sense_clr: assert property (p_sense_clr) else $error("Sense change kept flags."); // RL6
  property p_dir;
    (REQ_I.wr && REQ_I.addr == `GEV_OFS_CLK) |=> ##1 SHARED_OSC_PIN_OE_O == $past(REQ_I.wdata[4], 2);
  endproperty
  a_dir: assert property (p_dir) else $error("Pin direction wrong."); // RL8
  property p_fixed;
    (clk_r[3:0] == 4'hF) |=> SHARED_OSC_PIN_O;
  endproperty
  a_fixed: assert property (p_fixed) else $error("Fixed high level missing."); // RL9
  property p_off;
    (clk_r[6:5] == 2'b00) |-> !osc_frequency;
  endproperty
  a_off: assert property (p_off) else $error("Clock not off."); // RL7
  property p_none;
    (sense_r[1:0] == 2'b00) |-> !hit[0];
  endproperty
  a_none: assert property (p_none) else $error("Edge seen with sense none."); // RL11
endmodule
`default_nettype wire

//--- dv/gev_tb.sv
// Self-checking bench for the GPIO event block.
`timescale 1ns/1ps
`default_nettype none
`include "gev_cfg.svh"
module tb
  import gev_pkg::*;
;
  logic       clk;
  logic       rst;
  gev_req_t   req;
  logic [7:0] rdata;
  logic [3:0] io;
  logic       int_n;
  logic       int_oe;
  logic       osc_in;
  logic       osc_out;
  logic       osc_oe;
  int         n_mismatch;
  int         compares;

  gev_top gev_top_i (
    .CORE_CLK_I           (clk),
    .SYS_RST_I            (rst),
    .REQ_I                (req),
    .RDATA_O              (rdata),
    .IO_I                 (io),
    .INTERRUPT_OUT_N_O    (int_n),
    .INTERRUPT_OUT_N_OE_O (int_oe),
    .SHARED_OSC_PIN_I     (osc_in),
    .SHARED_OSC_PIN_O     (osc_out),
    .SHARED_OSC_PIN_OE_O  (osc_oe)
  );

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic stop_test();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    compares++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("[ERR] %0t osc toggles %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick();
    req = '{1'b1, a, d};
    tick();
    req.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    tick();
    req.addr = a;
    tick();
    chk8(rdata, exp, what);
  endtask

  // Bounded wait for the interrupt pin to reach a level.
  task automatic wait_int(input logic exp);
    for (int i = 0; i < 12 && int_oe !== exp; i++) tick();
    chk8({7'h0, int_oe}, {7'h0, exp}, "interrupt");
    if (int_oe !== exp) stop_test();
  endtask

  // Counts pin toggles over 400 cycles; the external clock toggles every 20.
  task automatic osc(input logic [7:0] cfg, input int lo, input int hi);
    int   n;
    logic last;
    n = 0;
    wr(`GEV_OFS_CLK, cfg);
    repeat (10) tick();
    last = osc_out;
    for (int i = 0; i < 400; i++) begin
      if (i % 20 == 0) osc_in = ~osc_in;
      tick();
      if (osc_out !== last) n++;
      last = osc_out;
    end
    chk_rng(n, lo, hi);
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    req = '0;
    io = 4'h0;
    osc_in = 1'b0;
    n_mismatch = 0;
    compares = 0;
    repeat (10) tick();
    rst = 1'b0;
    rd(`GEV_OFS_CLK, 8'h00, "clk reset");
    rd(`GEV_OFS_SRC, 8'h00, "src reset");
    rd(`GEV_OFS_EVT, 8'h00, "evt reset");
    rd(8'h1F, 8'h00, "unmapped");
    chk8({6'h0, int_oe, int_n}, 8'h00, "int idle");
    $display("test reset done");
    wr(`GEV_OFS_SENSE, 8'h07);
    wr(`GEV_OFS_MASK, 8'h0E);
    io = 4'h3;
    wait_int(1'b1);
    rd(`GEV_OFS_EVT, 8'h03, "evt both");
    rd(`GEV_OFS_SRC, 8'h01, "src masked");
    wr(`GEV_OFS_SRC, 8'h00);
    rd(`GEV_OFS_SRC, 8'h01, "w0 src");
    wr(`GEV_OFS_SRC, 8'hF1);
    wait_int(1'b0);
    rd(`GEV_OFS_EVT, 8'h02, "src clr evt");
    wr(`GEV_OFS_EVT, 8'h02);
    rd(`GEV_OFS_EVT, 8'h00, "evt w1c");
    io = 4'h0;
    wait_int(1'b1);
    rd(`GEV_OFS_EVT, 8'h01, "fall");
    wr(`GEV_OFS_EVT, 8'h01);
    wait_int(1'b0);
    rd(`GEV_OFS_SRC, 8'h00, "evt clr src");
    io = 4'h1;
    wait_int(1'b1);
    wr(`GEV_OFS_SENSE, 8'h06);
    wait_int(1'b0);
    rd(`GEV_OFS_EVT, 8'h00, "sense clr");
    $display("test events done");
    wr(`GEV_OFS_CLK, 8'hF0);
    rd(`GEV_OFS_CLK, 8'h70, "clk bit7");
    repeat (2) tick();
    chk8({6'h0, osc_oe, osc_out}, 8'h02, "gpo low");
    osc(8'h1F, 0, 0);
    chk8({6'h0, osc_oe, osc_out}, 8'h03, "gpo high");
    osc(8'h51, 7, 9);
    osc(8'h52, 3, 5);
    osc(8'h21, 19, 21);
    osc(8'h22, 9, 11);
    osc(8'h31, 0, 0);
    osc(8'h11, 0, 0);
    osc(8'h71, 0, 0);
    wr(`GEV_OFS_CLK, 8'h41);
    repeat (3) tick();
    chk8({7'h0, osc_oe}, 8'h00, "pin input");
    $display("test osc done");
    stop_test();
  end
endmodule
`default_nettype wire
